// *** src/sar_adc_pkg.sv ***
package sar_adc_pkg;

    // ------------------------------------------------------------------
    // Conversion geometry
    // ------------------------------------------------------------------
    localparam int unsigned RESULT_WIDTH      = 8;
    localparam int unsigned CLOCKS_PER_BIT    = 8;
    localparam int unsigned CONV_CLOCKS       = 64;
    localparam int unsigned PHASE_WIDTH       = 3;
    localparam int unsigned BIT_IDX_WIDTH     = 3;
    localparam int unsigned EOC_DELAY_MAX     = 8;
    localparam int unsigned LATCH_CLOCKS      = 1;

    // ------------------------------------------------------------------
    // Reset values and seeds
    // ------------------------------------------------------------------
    localparam logic [7:0] SAR_RESET_VAL      = 8'h00;
    localparam logic [7:0] SAR_SEED_VAL       = 8'h80;
    localparam logic [7:0] RESULT_RESET_VAL   = 8'h00;
    localparam logic [2:0] MSB_IDX            = 3'h7;
    localparam logic [2:0] LAST_PHASE         = 3'h7;
    localparam logic [2:0] EOC_DELAY_DEFAULT  = 3'h0;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ARMED   = 3'b001,
        ST_COMPARE = 3'b010,
        ST_DELAY   = 3'b011,
        ST_LATCH   = 3'b100
    } conv_state_t;

endpackage

// *** src/sar_step_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// Trial-step exchange between the sequencer and the approximation register.
interface sar_step_if;
    logic       seed;
    logic       decide;
    logic [2:0] bit_idx;
    logic       cmp_below;
    logic [7:0] code;

    modport seq (output seed, output decide, output bit_idx,
                 output cmp_below, input code);
    modport sar (input seed, input decide, input bit_idx,
                 input cmp_below, output code);
endinterface

`default_nettype wire

// *** src/sar_register.sv ***
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------------------
// Successive approximation register
// --------------------------------------------------------------------------
module sar_register
(
    // Clock and reset.
    input  wire logic  core_clk,
    input  wire logic  rst_b,
    // Step control.
    sar_step_if.sar    step
);

    logic [7:0] code_reg;

    // Bit 7 is the MSB, bit 0 the LSB; the code drives the ladder tap.
    assign step.code = code_reg;

    // One flop per code bit: seeded on start, decided while on trial, and
    // armed to one when the bit above has just been decided. Bits that are
    // neither keep their decided value. The index compare is done in int so
    // that the MSB is never armed by the LSB decision wrapping round.
    for (genvar i = 0; i < 8; i++)
    begin : g_bit
        always_ff @(posedge core_clk)
        begin
            if (!rst_b)
                code_reg[i] <= sar_adc_pkg::SAR_RESET_VAL[i];
            else if (step.seed)
                code_reg[i] <= sar_adc_pkg::SAR_SEED_VAL[i];
            else if (step.decide && int'(step.bit_idx) == i)
                code_reg[i] <= ~step.cmp_below;
            else if (step.decide && int'(step.bit_idx) == i + 1)
                code_reg[i] <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// *** src/sar_adc_conversion_control.sv ***
// Notes on behaviour
// - Start rising edge loads the register with only the MSB set.
// - Conversion begins only when start falls back low.
// - Bit under trial clears when input is below the trial reference.
// - After a decision the next lower bit is set, decided bits kept.
// - Comparing cycles run from MSB down until the LSB is decided.
// - Eight comparing cycles of eight clocks, 64 clocks per conversion.
// - Finished result goes to the output latch on the same edge as the flag rises.
// - Start pulse lowers the flag; completion and latching raise it.
// - Flag may loop back to start for continuous conversion.
// - A start during conversion resets the register and restarts.
// - Start edge to flag edge is 64 clocks plus 1-8 delay plus 1.
// - Result is captured in the data latch at conversion end.
// - Output enable high drives pins; low leaves them undriven.
// - Previous result stays visible until the new one is latched.
// - Register holds an 8-bit code, bit 7 MSB, bit 0 LSB.
// - Code selects ladder tap; the tap code is given out.
// - Data pin of weight one half carries the MSB.
`timescale 1ns/10ps
`default_nettype none

module sar_adc_conversion_control
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Host pins.
    input  wire logic        start,
    input  wire logic        out_en,
    input  wire logic [2:0]  eoc_delay,
    // Comparator.
    input  wire logic        cmp_below,
    // Ladder tap selection.
    output logic      [7:0]  tap_code,
    // Data pins, three-state.
    output logic      [7:0]  data_out,
    output logic      [7:0]  data_oe,
    // Status.
    output logic             eoc
);

    // ----------------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------------
    // Pins, bit index and phase counter are all sized for an eight-bit code
    // resolved in eight-clock comparing cycles. A package change that breaks
    // this geometry is refused here instead of giving a quietly wrong
    // conversion length.
    if (sar_adc_pkg::RESULT_WIDTH != 8)
    begin : g_bad_width
        $error("Result width must match the eight data pins.");
    end

    if ((1 << sar_adc_pkg::BIT_IDX_WIDTH) != sar_adc_pkg::RESULT_WIDTH)
    begin : g_bad_index
        $error("Bit index cannot address every result bit.");
    end

    if ((1 << sar_adc_pkg::PHASE_WIDTH) != sar_adc_pkg::CLOCKS_PER_BIT)
    begin : g_bad_phase
        $error("Phase counter must wrap after one comparing cycle.");
    end

    if (sar_adc_pkg::CLOCKS_PER_BIT * sar_adc_pkg::RESULT_WIDTH
        != sar_adc_pkg::CONV_CLOCKS)
    begin : g_bad_length
        $error("Conversion length must be bits times clocks per bit.");
    end

    if (sar_adc_pkg::EOC_DELAY_MAX != 8)
    begin : g_bad_delay
        $error("Delay select pin covers exactly one to eight clocks.");
    end

    if (sar_adc_pkg::LATCH_CLOCKS != 1)
    begin : g_bad_latch
        $error("The result latch takes exactly one clock.");
    end

    if (sar_adc_pkg::LAST_PHASE != 3'(sar_adc_pkg::CLOCKS_PER_BIT - 1))
    begin : g_bad_last
        $error("Last phase must be the final clock of a cycle.");
    end

    if (sar_adc_pkg::MSB_IDX != 3'(sar_adc_pkg::RESULT_WIDTH - 1))
    begin : g_bad_msb
        $error("First bit on trial must be the top result bit.");
    end

    if (sar_adc_pkg::SAR_SEED_VAL
        != 8'(1 << (sar_adc_pkg::RESULT_WIDTH - 1)))
    begin : g_bad_seed
        $error("Seed code must hold the top bit alone.");
    end

    // ----------------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------------
    logic       start_meta;
    logic       start_sync;
    logic       start_prev;
    logic       oe_meta;
    logic       oe_sync;
    logic       cmp_meta;
    logic       cmp_sync;
    logic [2:0] delay_meta;
    logic [2:0] delay_sync;

    // Every pin input passes two flops before any logic reads it. The delay
    // select is a static strap, so plain flops per bit are enough: it is
    // only read at a start rise, long after it has settled.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_prev <= 1'b0;
            oe_meta    <= 1'b0;
            oe_sync    <= 1'b0;
            cmp_meta   <= 1'b0;
            cmp_sync   <= 1'b0;
            delay_meta <= 3'h0;
            delay_sync <= 3'h0;
        end
        else
        begin
            start_meta <= start;
            start_sync <= start_meta;
            start_prev <= start_sync;
            oe_meta    <= out_en;
            oe_sync    <= oe_meta;
            cmp_meta   <= cmp_below;
            cmp_sync   <= cmp_meta;
            delay_meta <= eoc_delay;
            delay_sync <= delay_meta;
        end
    end

    // ----------------------------------------------------------------------
    // Start edge detection
    // ----------------------------------------------------------------------
    logic start_rise;
    logic start_fall;

    // Edges come from the second synchroniser stage and its delayed copy.
    // Both reset low, the idle level of the pin, so releasing reset with
    // the pin low never fakes a start.
    assign start_rise = start_sync & ~start_prev;
    assign start_fall = ~start_sync & start_prev;

    // ----------------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------------
    sar_adc_pkg::conv_state_t state_reg;
    logic [2:0]               phase_reg;
    logic [2:0]               bit_reg;
    logic [2:0]               delay_reg;
    logic [2:0]               delay_cfg_reg;
    logic                     last_phase;

    sar_step_if step ();

    // Step controls for the register: seed on any start rise, decide on
    // the last clock of each comparing cycle.
    assign last_phase     = (phase_reg == sar_adc_pkg::LAST_PHASE);
    assign step.seed      = start_rise;
    assign step.decide    = (state_reg == sar_adc_pkg::ST_COMPARE)
                            && last_phase;
    assign step.bit_idx   = bit_reg;
    assign step.cmp_below = cmp_sync;

    // The register keeps the code; this block only sequences it.
    sar_register u_sar
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .step     (step)
    );

    // The host delay pin sets the end-of-conversion delay; 0 means one clock.
    // Sampled at the start rise so a change mid-run cannot stretch it.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            delay_cfg_reg <= sar_adc_pkg::EOC_DELAY_DEFAULT;
        else if (start_rise)
            delay_cfg_reg <= delay_sync;
    end

    // State walk: armed on rise, compare after fall, delay, latch, idle.
    // A fresh start rise wins from any state, so a running conversion
    // restarts instead of finishing with a stale code.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            state_reg <= sar_adc_pkg::ST_IDLE;
        else if (start_rise)
            state_reg <= sar_adc_pkg::ST_ARMED;
        else
        begin
            case (state_reg)
                sar_adc_pkg::ST_IDLE:
                    state_reg <= sar_adc_pkg::ST_IDLE;
                sar_adc_pkg::ST_ARMED:
                    if (start_fall)
                        state_reg <= sar_adc_pkg::ST_COMPARE;
                sar_adc_pkg::ST_COMPARE:
                    if (last_phase && bit_reg == 3'h0)
                        state_reg <= sar_adc_pkg::ST_DELAY;
                sar_adc_pkg::ST_DELAY:
                    if (delay_reg == delay_cfg_reg)
                        state_reg <= sar_adc_pkg::ST_LATCH;
                sar_adc_pkg::ST_LATCH:
                    state_reg <= sar_adc_pkg::ST_IDLE;
                default:
                    state_reg <= sar_adc_pkg::ST_IDLE;
            endcase
        end
    end

    // Clock-within-cycle counter: eight clocks per comparing cycle.
    // It wraps by itself, so the next bit starts with no extra compare.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            phase_reg <= 3'h0;
        else if (state_reg != sar_adc_pkg::ST_COMPARE || start_rise)
            phase_reg <= 3'h0;
        else
            phase_reg <= phase_reg + 3'h1;
    end

    // Bit under trial, stepping from MSB toward LSB.
    // It stops at the LSB; the state walk leaves compare on that decision.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            bit_reg <= sar_adc_pkg::MSB_IDX;
        else if (start_rise)
            bit_reg <= sar_adc_pkg::MSB_IDX;
        else if (step.decide && bit_reg != 3'h0)
            bit_reg <= bit_reg - 3'h1;
    end

    // End-of-conversion delay counter.
    // Counts from zero in the delay state; leaving on a match with the
    // stored select gives select plus one delay clocks.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            delay_reg <= 3'h0;
        else if (state_reg != sar_adc_pkg::ST_DELAY)
            delay_reg <= 3'h0;
        else
            delay_reg <= delay_reg + 3'h1;
    end

    // ----------------------------------------------------------------------
    // Output latch and pins
    // ----------------------------------------------------------------------
    // The data pin flop is the result latch itself. It loads on the same
    // edge as the flag rises, so a host that reads on the flag never sees
    // the previous code; a separate pin stage would lag the flag a clock.
    // It only loads in the latch state, so the old result stays on the
    // pins for the whole of the next conversion; a restart in the latch
    // state drops the finished code. Bit 7 is the weight-one-half pin.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            data_out <= sar_adc_pkg::RESULT_RESET_VAL;
        else if (state_reg == sar_adc_pkg::ST_LATCH && !start_rise)
            data_out <= step.code;
    end

    // Pin enable and ladder tap are registered so every output comes
    // straight from a flop; the tap runs one clock behind the code, which
    // the comparator synchroniser has to wait out in any case.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            data_oe  <= 8'h00;
            tap_code <= sar_adc_pkg::SAR_RESET_VAL;
        end
        else
        begin
            data_oe  <= {8{oe_sync}};
            tap_code <= step.code;
        end
    end

    // Flag falls on a start rise and rises on the edge that leaves the
    // latch state, together with the new result on the pins, so a
    // looped-back flag retriggers cleanly for continuous conversion. A
    // start rise in the latch state wins: the restart drops that result.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            eoc <= 1'b0;
        else if (start_rise)
            eoc <= 1'b0;
        else if (state_reg == sar_adc_pkg::ST_LATCH)
            eoc <= 1'b1;
    end

endmodule

`default_nettype wire

// *** testbench/sar_adc_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----
// Checker
// ----
module sar_adc_monitor
(
    // Clock and reset.
    input wire logic       core_clk,
    input wire logic       rst_b,
    // Pins of the block.
    input wire logic       start,
    input wire logic       out_en,
    input wire logic [2:0] eoc_delay,
    input wire logic       cmp_below,
    input wire logic [7:0] tap_code,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic       eoc
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] prev_q;
    logic [7:0] cyc_q;
    logic [7:0] trial;
    // Previous code, and clocks since start was last seen high.
    always_ff @(posedge core_clk)
    begin
        prev_q <= tap_code;
        if (!rst_b || start)
            cyc_q <= 8'h00;
        else if (cyc_q != 8'hff)
            cyc_q <= cyc_q + 8'h01;
    end
    // Lowest set bit of the previous code is the bit that was on trial.
    assign trial = prev_q & (~prev_q + 8'h01);
    property p_seed;
        $rose(start) |-> ##[3:6] tap_code == 8'h80;
    endproperty
    a_seed: assert property (p_seed)
        else $error("seed code missing");
    property p_clear;
        $rose(start) |-> ##[2:6] !eoc;
    endproperty
    a_clear: assert property (p_clear)
        else $error("flag not lowered");
    property p_cause;
        $fell(eoc) |-> $past(start, 2) || $past(start, 3) || $past(start, 4);
    endproperty
    a_cause: assert property (p_cause)
        else $error("flag fell without start");
    property p_step;
        $changed(tap_code) && tap_code != 8'h80 |->
            tap_code == (prev_q | (trial >> 1)) ||
            tap_code == ((prev_q & ~trial) | (trial >> 1));
    endproperty
    a_step: assert property (p_step)
        else $error("bad trial step");
    property p_hold;
        $changed(tap_code) && tap_code != 8'h80 |=>
            (tap_code == 8'h80 || $stable(tap_code)) [*7];
    endproperty
    a_hold: assert property (p_hold)
        else $error("comparing cycle too short");
    property p_time;
        $rose(eoc) |-> cyc_q >= 8'h42 && cyc_q <= 8'h50;
    endproperty
    a_time: assert property (p_time)
        else $error("conversion time out of range");
    property p_latch;
        $changed(data_out) && $stable(data_oe) |-> ##[0:2] eoc;
    endproperty
    a_latch: assert property (p_latch)
        else $error("result changed mid conversion");
    property p_oe;
        $stable(out_en) [*5] |-> data_oe == {8{out_en}};
    endproperty
    a_oe: assert property (p_oe)
        else $error("output enable mismatch");
endmodule
`default_nettype wire

// *** testbench/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----
// Host and analog side
// ----
module host_model
(
    // Clock.
    input  wire logic       core_clk,
    // Settings from the bench.
    input  wire logic [7:0] vin,
    input  wire logic       loop_en,
    // Device pins.
    input  wire logic [7:0] tap_code,
    input  wire logic       eoc,
    output logic            start,
    output logic            cmp_below
);
    logic pulse_q = 1'b0;
    // Loop-back ties the flag to start, so each rise restarts at once.
    assign start = loop_en ? eoc : pulse_q;
    // A zero code selects the bottom reference, which no input is below.
    assign cmp_below = vin < tap_code;
    // Start pulse, changed just after the edge and held for width clocks.
    task automatic pulse(input int width);
        @(posedge core_clk);
        pulse_q <= 1'b1;
        repeat (width) @(posedge core_clk);
        pulse_q <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/test_sar_adc_conversion_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_conversion_control;
    logic       core_clk, rst_b, out_en, loop_en, start, cmp_below, eoc;
    logic [2:0] eoc_delay;
    logic [7:0] vin, tap_code, data_out, data_oe;
    int         n_fail = 0, tests_run = 0, t0, t7, n;
    sar_adc_conversion_control dut (.core_clk(core_clk), .rst_b(rst_b),
        .start(start), .out_en(out_en), .eoc_delay(eoc_delay),
        .cmp_below(cmp_below), .tap_code(tap_code), .data_out(data_out),
        .data_oe(data_oe), .eoc(eoc));
    host_model host (.core_clk(core_clk), .vin(vin), .loop_en(loop_en),
        .tap_code(tap_code), .eoc(eoc), .start(start),
        .cmp_below(cmp_below));
    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [7:0] got, exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Bounded wait so a stuck flag cannot hang the run.
    task automatic wait_eoc(output int c);
        c = 0;
        while (eoc !== 1'b1 && c < 200)
        begin
            @(posedge core_clk);
            #1;
            c++;
        end
        check({7'h00, eoc}, 8'h01, "flag high");
    endtask
    task automatic convert(input logic [7:0] v, input logic [2:0] d,
                           output int c);
        @(posedge core_clk);
        vin <= v;
        eoc_delay <= d;
        host.pulse(6);
        #1;
        check({7'h00, eoc}, 8'h00, "flag low");
        wait_eoc(c);
        check(data_out, v, "result");
    endtask
    // ----
    // Scenarios
    // ----
    task automatic test_values();
        logic [7:0] v [6] = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h80, 8'h01};
        foreach (v[i]) convert(v[i], 3'h0, n);
        $display("test_values finished");
    endtask
    task automatic test_delay();
        convert(8'h3c, 3'h0, t0);
        convert(8'hc3, 3'h7, t7);
        check(8'(t7 - t0), 8'h07, "delay span");
        check(8'(t0 > 64 && t0 < 80), 8'h01, "length");
        $display("test_delay finished");
    endtask
    task automatic test_hold();
        @(posedge core_clk);
        vin <= 8'h11;
        host.pulse(6);
        repeat (30) @(posedge core_clk);
        #1;
        check(data_out, 8'hc3, "old result kept");
        wait_eoc(n);
        check(data_out, 8'h11, "new result");
        $display("test_hold finished");
    endtask
    task automatic test_restart();
        @(posedge core_clk);
        vin <= 8'h22;
        eoc_delay <= 3'h0;
        host.pulse(6);
        repeat (20) @(posedge core_clk);
        vin <= 8'h99;
        host.pulse(6);
        wait_eoc(n);
        check(data_out, 8'h99, "restart result");
        check(8'(n), 8'(t0), "restart time");
        $display("test_restart finished");
    endtask
    task automatic test_oe();
        @(posedge core_clk);
        out_en <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        check(data_oe, 8'h00, "pins released");
        @(posedge core_clk);
        out_en <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        check(data_oe, 8'hff, "pins driven");
        $display("test_oe finished");
    endtask
    task automatic test_loop();
        int p [3];
        @(posedge core_clk);
        vin <= 8'h6e;
        loop_en <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            p[i] = 0;
            while (eoc !== 1'b0 && p[i] < 20)
            begin
                @(posedge core_clk);
                #1;
                p[i]++;
            end
            check({7'h00, eoc}, 8'h00, "loop flag low");
            wait_eoc(n);
            p[i] += n;
        end
        check(8'(p[2]), 8'(p[1]), "loop period");
        check(data_out, 8'h6e, "loop result");
        @(posedge core_clk);
        loop_en <= 1'b0;
        $display("test_loop finished");
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compared, %0d mismatched", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----
    // Clock, watchdog and main sequence
    // ----
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Far above the roughly 1050 clocks the scenarios need.
    initial
    begin
        repeat (8000) @(posedge core_clk);
        n_fail++;
        print_verdict();
    end
    initial
    begin
        rst_b = 1'b0;
        out_en = 1'b0;
        loop_en = 1'b0;
        vin = 8'h00;
        eoc_delay = 3'h0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        out_en <= 1'b1;
        repeat (6) @(posedge core_clk);
        test_values();
        test_delay();
        test_hold();
        test_restart();
        test_oe();
        test_loop();
        print_verdict();
    end
endmodule
bind sar_adc_conversion_control sar_adc_monitor mon (.core_clk(core_clk),
    .rst_b(rst_b), .start(start), .out_en(out_en), .eoc_delay(eoc_delay),
    .cmp_below(cmp_below), .tap_code(tap_code), .data_out(data_out),
    .data_oe(data_oe), .eoc(eoc));
`default_nettype wire
